// *** dpsc_top.sv ***
// Functional notes
// - Each channel has an input register feeding an active register; only active acts.
// - Word bits 3:2 pick which input registers load: none, A, B or both.
// - Word bits 1:0 pick which active registers load: none, A, B or both.
// - Serial-port register updates happen at chip select rising, never during shifting; the load pin acts at any time.
// - All four address and transfer bits zero leaves every register unchanged.
// - Transfer bits zero update only input registers unless the load pin is low.
// - Load pin low copies both input registers into active registers, independent of port.
// - New input data while load pin is low passes into the active register too.
// - Addressed channel with transfer set loads both ranks from the shift register.
// - Transfer without address copies existing input register; the other input register stays.
// - Shifted-out bits appear on the data output for daisy-chaining.
// - Bit 15 selects input, bit 14 force current, bit 13 measure voltage.
// - Bit 8 low floats the driver; measure must then be voltage.
// - Measure-float pin low places the measure output in high impedance.
// - Bit 6 low floats both comparator outputs of that channel.
// - Range bits decode to E, E, D, C, B, A, external, A; external drives select.
// - Measure output enabled only when float bit and float pin are both high.
// - Chip select pulse without clocks loads input registers into active registers.
// - Data output changes on falling clock, first bit after 16.5 cycles.
`timescale 1ns/100ps
module dpsc_top (
  // System clock and control
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // Serial link
  input  wire logic       sclk_link,
  input  wire logic       cs_n,
  input  wire logic       din,
  output logic            dout,
  // Asynchronous pins
  input  wire logic       load_n,
  input  wire logic [1:0] meas_float_pin_n,
  input  wire logic [1:0] cmp_high,
  input  wire logic [1:0] cmp_low,
  // Per-channel decoded state, bit 0 is channel A
  output logic [1:0]      in_sel,
  output logic [1:0]      force_curr,
  output logic [1:0]      meas_volt,
  output logic [5:0]      range_sel,
  output logic [9:0]      range_en,
  output logic [1:0]      ext_range_out,
  output logic [1:0]      clamp_on,
  output logic [1:0]      force_en,
  output logic [1:0]      measure_out_en,
  // Open-drain comparator pins
  output logic [1:0]      over_window_n,
  output logic [1:0]      over_window_oe,
  output logic [1:0]      under_window_n,
  output logic [1:0]      under_window_oe
);

  // Link domain.
  logic        link_rst_meta_r;
  logic        link_rst_b_r;
  logic [15:0] shift_r;
  logic        out_bit_r;
  logic        edge_tog_r;
  logic        dout_r;

  // The serial clock only runs when the host wants it; the reset is taken on its edges.
  always_ff @(posedge sclk_link) begin
    link_rst_meta_r <= rst_b;
    link_rst_b_r    <= link_rst_meta_r;
  end

  always_ff @(posedge sclk_link) begin
    if (!link_rst_b_r) begin
      shift_r    <= dpsc_pkg::WORD_RESET;
      out_bit_r  <= 1'b0;
      edge_tog_r <= 1'b0;
    end else if (!cs_n) begin
      shift_r    <= {shift_r[14:0], din};
      out_bit_r  <= shift_r[15];
      edge_tog_r <= ~edge_tog_r;
    end
  end

  // One extra stage plus the falling edge gives the 16.5 cycle chain delay.
  always_ff @(negedge sclk_link) begin
    if (!link_rst_b_r) begin
      dout_r <= 1'b0;
    end else begin
      dout_r <= out_bit_r;
    end
  end

  assign dout = dout_r;

  // System domain.
  logic [8:0]               sync_in;
  logic [8:0]               sync_q;
  logic                     cs_n_s;
  logic                     load_n_s;
  logic                     tog_s;
  logic [1:0]               meas_pin_s;
  logic [1:0]               cmp_high_s;
  logic [1:0]               cmp_low_s;
  dpsc_pkg::dpsc_frame_type state_r;
  logic                     tog_start_r;
  logic                     clocked_r;
  logic [15:0]              word_r;
  logic                     commit_r;
  logic                     quick_r;

  assign sync_in = {cmp_low, cmp_high, meas_float_pin_n, edge_tog_r, load_n, cs_n};

  dpsc_sync #(
    .W (dpsc_pkg::SYNC_W)
  ) u_sync (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .async_in  (sync_in),
    .reset_val (dpsc_pkg::SYNC_RESET),
    .sync_out  (sync_q)
  );

  assign cs_n_s     = sync_q[0];
  assign load_n_s   = sync_q[1];
  assign tog_s      = sync_q[2];
  assign meas_pin_s = sync_q[4:3];
  assign cmp_high_s = sync_q[6:5];
  assign cmp_low_s  = sync_q[8:7];

  // The shift register is still by the time the synchronised select has risen,
  // so the word is taken whole without per-bit synchronisers.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r     <= dpsc_pkg::DPSC_IDLE;
      tog_start_r <= 1'b0;
      clocked_r   <= 1'b0;
    end else if (ce) begin
      unique case (state_r)
        dpsc_pkg::DPSC_IDLE: begin
          if (!cs_n_s) begin
            state_r     <= dpsc_pkg::DPSC_FRAME;
            tog_start_r <= tog_s;
            clocked_r   <= 1'b0;
          end
        end
        dpsc_pkg::DPSC_FRAME: begin
          // An even bit count returns the toggle to its start, so any change marks a clocked frame.
          if (tog_s != tog_start_r) begin
            clocked_r <= 1'b1;
          end
          if (cs_n_s) begin
            state_r <= dpsc_pkg::DPSC_COMMIT;
          end
        end
        dpsc_pkg::DPSC_COMMIT: begin
          state_r <= dpsc_pkg::DPSC_IDLE;
        end
        default: begin
          state_r <= dpsc_pkg::DPSC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      word_r   <= dpsc_pkg::WORD_RESET;
      commit_r <= 1'b0;
      quick_r  <= 1'b0;
    end else if (ce) begin
      commit_r <= 1'b0;
      quick_r  <= 1'b0;
      if (state_r == dpsc_pkg::DPSC_COMMIT) begin
        if (!clocked_r) begin
          quick_r <= 1'b1;
        end else begin
          word_r   <= shift_r;
          commit_r <= 1'b1;
        end
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < dpsc_pkg::N_CHAN; ch++) begin : g_chan
      dpsc_chan u_chan (
        .clk               (clk),
        .rst_b             (rst_b),
        .ce                (ce),
        .word              (word_r),
        .commit            (commit_r),
        .quick_load        (quick_r),
        .dest              (word_r[dpsc_pkg::DEST_CHAN_A_BIT + ch]),
        .xfer              (word_r[dpsc_pkg::XFER_CHAN_A_BIT + ch]),
        .load_level        (~load_n_s),
        .meas_float_pin_n  (meas_pin_s[ch]),
        .cmp_high          (cmp_high_s[ch]),
        .cmp_low           (cmp_low_s[ch]),
        .in_sel_r          (in_sel[ch]),
        .force_curr_r      (force_curr[ch]),
        .meas_volt_r       (meas_volt[ch]),
        .range_sel_r       (range_sel[3*ch +: 3]),
        .range_en_r        (range_en[5*ch +: 5]),
        .ext_range_out_r   (ext_range_out[ch]),
        .clamp_on_r        (clamp_on[ch]),
        .force_en_r        (force_en[ch]),
        .measure_out_en_r  (measure_out_en[ch]),
        .over_window_n_r   (over_window_n[ch]),
        .over_window_oe_r  (over_window_oe[ch]),
        .under_window_n_r  (under_window_n[ch]),
        .under_window_oe_r (under_window_oe[ch])
      );
    end
  endgenerate

endmodule

// *** dpsc_pkg.sv ***
package dpsc_pkg;

  // Control word layout.
  localparam int unsigned WORD_W           = 16;
  localparam int unsigned N_CHAN           = 2;
  localparam int unsigned IN_SEL_BIT       = 15;
  localparam int unsigned FORCE_CURR_BIT   = 14;
  localparam int unsigned MEAS_VOLT_BIT    = 13;
  localparam int unsigned RANGE_MSB        = 12;
  localparam int unsigned RANGE_LSB        = 10;
  localparam int unsigned CLAMP_ON_BIT     = 9;
  localparam int unsigned DRIVER_FLOAT_BIT = 8;
  localparam int unsigned MEAS_FLOAT_BIT   = 7;
  localparam int unsigned CMP_ENABLE_BIT   = 6;
  localparam int unsigned DEST_CHAN_A_BIT  = 2;
  localparam int unsigned XFER_CHAN_A_BIT  = 0;

  // Reset value of every input and active register: driver, measure and comparators float.
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Range codes and one-hot range enables, bit 0 is range A, bit 4 range E.
  localparam logic [2:0] RANGE_CODE_E0  = 3'h0;
  localparam logic [2:0] RANGE_CODE_E1  = 3'h1;
  localparam logic [2:0] RANGE_CODE_D   = 3'h2;
  localparam logic [2:0] RANGE_CODE_C   = 3'h3;
  localparam logic [2:0] RANGE_CODE_B   = 3'h4;
  localparam logic [2:0] RANGE_CODE_A0  = 3'h5;
  localparam logic [2:0] RANGE_CODE_EXT = 3'h6;
  localparam logic [2:0] RANGE_CODE_A1  = 3'h7;
  localparam logic [4:0] RANGE_EN_A     = 5'h01;
  localparam logic [4:0] RANGE_EN_B     = 5'h02;
  localparam logic [4:0] RANGE_EN_C     = 5'h04;
  localparam logic [4:0] RANGE_EN_D     = 5'h08;
  localparam logic [4:0] RANGE_EN_E     = 5'h10;
  localparam logic [4:0] RANGE_EN_NONE  = 5'h00;

  // Synchronised pin group layout.
  localparam int unsigned SYNC_W = 9;
  // Select and load pins rest high, so no false frame or load follows reset.
  localparam logic [8:0]  SYNC_RESET = 9'h003;

  typedef enum logic [1:0] {
    DPSC_IDLE   = 2'b00,
    DPSC_FRAME  = 2'b01,
    DPSC_COMMIT = 2'b11
  } dpsc_frame_type;

endpackage

// *** dpsc_sync.sv ***
`timescale 1ns/100ps
module dpsc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r   <= reset_val;
      sync_out <= reset_val;
    end else if (ce) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** dpsc_chan.sv ***
`timescale 1ns/100ps
module dpsc_chan (
  // Clock and control
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // Commands from the serial port and the synchronised load pin
  input  wire logic [15:0] word,
  input  wire logic        commit,
  input  wire logic        quick_load,
  input  wire logic        dest,
  input  wire logic        xfer,
  input  wire logic        load_level,
  // Synchronised pins
  input  wire logic        meas_float_pin_n,
  input  wire logic        cmp_high,
  input  wire logic        cmp_low,
  // Decoded channel state
  output logic             in_sel_r,
  output logic             force_curr_r,
  output logic             meas_volt_r,
  output logic [2:0]       range_sel_r,
  output logic [4:0]       range_en_r,
  output logic             ext_range_out_r,
  output logic             clamp_on_r,
  output logic             force_en_r,
  output logic             measure_out_en_r,
  output logic             over_window_n_r,
  output logic             over_window_oe_r,
  output logic             under_window_n_r,
  output logic             under_window_oe_r
);

  logic [15:0] input_r;
  logic [15:0] active_r;
  logic        cmp_en;

  assign cmp_en = active_r[dpsc_pkg::CMP_ENABLE_BIT];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      input_r <= dpsc_pkg::WORD_RESET;
    end else if (ce && commit && dest) begin
      input_r <= word;
    end
  end

  // A held load pin passes freshly addressed data straight through.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      active_r <= dpsc_pkg::WORD_RESET;
    end else if (ce) begin
      if (commit && dest && (xfer || load_level)) begin
        active_r <= word;
      end else if ((commit && xfer) || quick_load || load_level) begin
        active_r <= input_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_sel_r         <= 1'b0;
      force_curr_r     <= 1'b0;
      meas_volt_r      <= 1'b0;
      range_sel_r      <= dpsc_pkg::RANGE_CODE_E0;
      clamp_on_r       <= 1'b0;
      force_en_r       <= 1'b0;
      measure_out_en_r <= 1'b0;
    end else if (ce) begin
      in_sel_r         <= active_r[dpsc_pkg::IN_SEL_BIT];
      force_curr_r     <= active_r[dpsc_pkg::FORCE_CURR_BIT];
      // A floating driver cannot measure current, so the voltage path is forced.
      meas_volt_r      <= active_r[dpsc_pkg::MEAS_VOLT_BIT] |
                          ~active_r[dpsc_pkg::DRIVER_FLOAT_BIT];
      range_sel_r      <= active_r[dpsc_pkg::RANGE_MSB:dpsc_pkg::RANGE_LSB];
      clamp_on_r       <= active_r[dpsc_pkg::CLAMP_ON_BIT];
      force_en_r       <= active_r[dpsc_pkg::DRIVER_FLOAT_BIT];
      measure_out_en_r <= active_r[dpsc_pkg::MEAS_FLOAT_BIT] & meas_float_pin_n;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      range_en_r      <= dpsc_pkg::RANGE_EN_E;
      ext_range_out_r <= 1'b0;
    end else if (ce) begin
      unique case (active_r[dpsc_pkg::RANGE_MSB:dpsc_pkg::RANGE_LSB])
        dpsc_pkg::RANGE_CODE_E0,
        dpsc_pkg::RANGE_CODE_E1: begin
          range_en_r      <= dpsc_pkg::RANGE_EN_E;
          ext_range_out_r <= 1'b0;
        end
        dpsc_pkg::RANGE_CODE_D: begin
          range_en_r      <= dpsc_pkg::RANGE_EN_D;
          ext_range_out_r <= 1'b0;
        end
        dpsc_pkg::RANGE_CODE_C: begin
          range_en_r      <= dpsc_pkg::RANGE_EN_C;
          ext_range_out_r <= 1'b0;
        end
        dpsc_pkg::RANGE_CODE_B: begin
          range_en_r      <= dpsc_pkg::RANGE_EN_B;
          ext_range_out_r <= 1'b0;
        end
        dpsc_pkg::RANGE_CODE_EXT: begin
          range_en_r      <= dpsc_pkg::RANGE_EN_NONE;
          ext_range_out_r <= 1'b1;
        end
        dpsc_pkg::RANGE_CODE_A0,
        dpsc_pkg::RANGE_CODE_A1: begin
          range_en_r      <= dpsc_pkg::RANGE_EN_A;
          ext_range_out_r <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain comparator pins: data is always low, the enable pulls the line.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      over_window_n_r   <= 1'b0;
      over_window_oe_r  <= 1'b0;
      under_window_n_r  <= 1'b0;
      under_window_oe_r <= 1'b0;
    end else if (ce) begin
      over_window_n_r   <= 1'b0;
      under_window_n_r  <= 1'b0;
      over_window_oe_r  <= cmp_en & cmp_high;
      under_window_oe_r <= cmp_en & cmp_low;
    end
  end

endmodule

// *** dpsc_host_model.sv ***
`timescale 1ns/100ps
module dpsc_host_model (
  // Serial link driven by the host
  output logic sclk_link,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk_link = 1'b0;
    cs_n      = 1'b1;
    din       = 1'b1;
  end
  // Clocks with the port deselected, used only while the link side takes and leaves reset.
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #16 sclk_link = 1'b1;
      #16 sclk_link = 1'b0;
    end
  endtask
  // Whole words msb first; zero bits gives a bare select pulse.
  task automatic frame(input logic [15:0] w, input int nbits);
    #3 cs_n = 1'b0;
    #40;
    for (int i = nbits - 1; i >= 0; i--) begin
      din = w[i];
      #16 sclk_link = 1'b1;
      #16 sclk_link = 1'b0;
    end
    din = ~din;
    #40 cs_n = 1'b1;
  endtask
endmodule

// *** dpsc_top_props.sv ***
`timescale 1ns/100ps
module dpsc_top_props (
  // Clocks and reset
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       sclk_link,
  // Serial link and pins
  input wire logic       cs_n,
  input wire logic       din,
  input wire logic       dout,
  input wire logic       load_n,
  input wire logic [1:0] meas_float_pin_n,
  input wire logic [1:0] cmp_high,
  input wire logic [1:0] cmp_low,
  // Decoded state
  input wire logic [1:0] in_sel,
  input wire logic [1:0] force_curr,
  input wire logic [1:0] meas_volt,
  input wire logic [5:0] range_sel,
  input wire logic [9:0] range_en,
  input wire logic [1:0] ext_range_out,
  input wire logic [1:0] force_en,
  input wire logic [1:0] measure_out_en,
  input wire logic [1:0] over_window_n,
  input wire logic [1:0] over_window_oe,
  input wire logic [1:0] under_window_n,
  input wire logic [1:0] under_window_oe
);
  logic [17:0] hist_r;
  // History is fed only while selected, so gaps between frames do not shift it.
  always_ff @(posedge sclk_link) begin
    if (!rst_b) begin
      hist_r <= 18'h00000;
    end else if (!cs_n) begin
      hist_r <= {hist_r[16:0], din};
    end
  end
  function automatic logic [4:0] ren(input logic [2:0] rs);
    case (rs)
      3'h0, 3'h1: return 5'h10;
      3'h2:       return 5'h08;
      3'h3:       return 5'h04;
      3'h4:       return 5'h02;
      3'h6:       return 5'h00;
      default:    return 5'h01;
    endcase
  endfunction
  property p_dout;
    @(negedge sclk_link) disable iff (!rst_b) !cs_n |-> dout == hist_r[17];
  endproperty
  a_dout: assert property (p_dout) else $error("chain output out of step");
  property p_hold;
    @(posedge clk) disable iff (!rst_b) (cs_n && load_n)[*8] ##1 (cs_n && load_n)
      |-> $stable(in_sel) && $stable(force_curr) && $stable(range_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while idle");
  property p_ext;
    @(posedge clk) disable iff (!rst_b) ext_range_out[0] == (range_sel[2:0] == 3'h6);
  endproperty
  a_ext: assert property (p_ext) else $error("external select wrong");
  property p_ren;
    @(posedge clk) disable iff (!rst_b) range_en[9:5] == ren(range_sel[5:3]);
  endproperty
  a_ren: assert property (p_ren) else $error("range enable wrong");
  property p_float_mv;
    @(posedge clk) disable iff (!rst_b) $past(rst_b, 2) && !force_en[1] |-> meas_volt[1];
  endproperty
  a_float_mv: assert property (p_float_mv) else $error("floating driver measures current");
  property p_mpin;
    @(posedge clk) disable iff (!rst_b) (!meas_float_pin_n[0])[*5] |-> !measure_out_en[0];
  endproperty
  a_mpin: assert property (p_mpin) else $error("measure output not floated");
  property p_men;
    @(posedge clk) disable iff (!rst_b) measure_out_en[1] |-> $past(meas_float_pin_n[1], 3);
  endproperty
  a_men: assert property (p_men) else $error("measure enabled with pin low");
  property p_cmp;
    @(posedge clk) disable iff (!rst_b) over_window_oe[0] |-> $past(cmp_high[0], 3);
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator pulls without cause");
  property p_od;
    @(posedge clk) disable iff (!rst_b) (!cmp_low[1])[*5] |-> !under_window_oe[1]
      && over_window_n == 2'h0 && under_window_n == 2'h0;
  endproperty
  a_od: assert property (p_od) else $error("open drain misbehaves");
  c_ext: cover property (@(posedge clk) ext_range_out[0]);
  c_load: cover property (@(posedge clk) !load_n);
  c_cmp: cover property (@(posedge clk) over_window_oe[1]);
endmodule
bind dpsc_top dpsc_top_props u_props (.clk, .rst_b, .sclk_link, .cs_n, .din, .dout, .load_n,
  .meas_float_pin_n, .cmp_high, .cmp_low, .in_sel, .force_curr, .meas_volt, .range_sel,
  .range_en, .ext_range_out, .force_en, .measure_out_en, .over_window_n, .over_window_oe,
  .under_window_n, .under_window_oe);

// *** tb_dual_pmu_serial_control.sv ***
`timescale 1ns/100ps
module tb_dual_pmu_serial_control;
  logic        clk, rst_b, ce, sclk_link, cs_n, din, dout, load_n;
  logic [1:0]  meas_float_pin_n, cmp_high, cmp_low, in_sel, force_curr, meas_volt;
  logic [1:0]  ext_range_out, clamp_on, force_en, measure_out_en;
  logic [1:0]  over_window_n, over_window_oe, under_window_n, under_window_oe;
  logic [5:0]  range_sel;
  logic [9:0]  range_en;
  logic [15:0] in_m [2];
  logic [15:0] act_m [2];
  logic [31:0] seed = 32'h0000005D;
  int          errors = 0;
  int          tests_run = 0;
  dpsc_top dut (.clk, .rst_b, .ce, .sclk_link, .cs_n, .din, .dout, .load_n, .meas_float_pin_n,
    .cmp_high, .cmp_low, .in_sel, .force_curr, .meas_volt, .range_sel, .range_en,
    .ext_range_out, .clamp_on, .force_en, .measure_out_en, .over_window_n, .over_window_oe,
    .under_window_n, .under_window_oe);
  dpsc_host_model host (.sclk_link, .cs_n, .din);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [18:0] expect_chan(input int c);
    logic [15:0] w;
    logic [4:0]  en;
    w = act_m[c];
    case (w[12:10])
      3'h0, 3'h1: en = 5'h10;
      3'h2:       en = 5'h08;
      3'h3:       en = 5'h04;
      3'h4:       en = 5'h02;
      3'h6:       en = 5'h00;
      default:    en = 5'h01;
    endcase
    return {w[15:14], w[13] | ~w[8], w[12:10], en, w[12:10] == 3'h6, w[9:8],
      w[7] & meas_float_pin_n[c], 1'b0, w[6] & cmp_high[c], 1'b0, w[6] & cmp_low[c]};
  endfunction
  function automatic logic [18:0] seen_chan(input int c);
    return {in_sel[c], force_curr[c], meas_volt[c], range_sel[3*c+:3], range_en[5*c+:5],
      ext_range_out[c], clamp_on[c], force_en[c], measure_out_en[c], over_window_n[c],
      over_window_oe[c], under_window_n[c], under_window_oe[c]};
  endfunction
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Fixed settle covers the worst commit path plus the pin synchronisers.
  task automatic verify();
    repeat (12) @(posedge clk);
    chk(seen_chan(0), expect_chan(0));
    chk(seen_chan(1), expect_chan(1));
  endtask
  task automatic send(input logic [15:0] w, input int nbits);
    host.frame(w, nbits);
    for (int c = 0; c < 2; c++) begin
      if (nbits == 16 && w[2+c]) in_m[c] = w;
      if (nbits == 0 || w[c] || !load_n) act_m[c] = in_m[c];
    end
    verify();
  endtask
  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    rst_b <= 1'b0;
    ce <= 1'b1;
    load_n <= 1'b1;
    meas_float_pin_n <= 2'h3;
    cmp_high <= 2'h0;
    cmp_low <= 2'h0;
    in_m = '{16'h0000, 16'h0000};
    act_m = '{16'h0000, 16'h0000};
    fork
      host.idle_clocks(4);
    join_none
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // The link side leaves reset only on serial clock edges.
    host.idle_clocks(4);
    verify();
    for (int i = 0; i < 64; i++) begin
      r = rnd();
      @(posedge clk);
      meas_float_pin_n <= r[1:0];
      cmp_high <= r[3:2];
      cmp_low <= r[5:4];
      send({r[15:13], i[5:3], r[9:4], i[3:0]}, 16);
    end
    send(16'h5B38, 16);
    @(posedge clk);
    load_n <= 1'b0;
    act_m = in_m;
    verify();
    send(16'hA5C4, 16);
    @(posedge clk);
    load_n <= 1'b1;
    send(16'h3E64, 16);
    send(16'h0000, 0);
    complete_run();
  end
endmodule
